// ===== hw/analog_comparator_ctrl.v
// register file and edge logic wrapping the analog comparator core
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defs.vh"
module analog_comparator_ctrl #(
	parameter DAC_BITS = 6,
	parameter SYNC_STAGES = 2
) (
	input wire CORE_CLK_I,
	input wire RST_I,
	input wire [`CMP_ADDR_W-1:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	output reg [31:0] AVS_READDATA_O,
	output wire AVS_WAITREQUEST_O,
	input wire COMPARATOR_RAW_I,
	output wire COMPARATOR_ENABLE_O,
	output wire HYSTERESIS_SEL_O,
	output wire [1:0] POSITIVE_INPUT_SELECT_O,
	output wire [1:0] NEGATIVE_INPUT_SELECT_O,
	output wire [DAC_BITS-1:0] DAC_CODE_O,
	output wire DAC_REF_SEL_O,
	output wire DAC_ENABLE_O,
	output wire [7:0] CONTROL_TWO_O,
	output reg PIN_OUT_O,
	output wire PIN_OE_O,
	output wire EDGE_IRQ_O,
	output wire IRQ_O
);
	reg [7:0] cs_reg;
	reg [7:0] in_sel;
	reg [7:0] ctrl_one;
	reg [7:0] ctrl_two;
	reg [`STAT_W-1:0] irq_status;
	reg [`STAT_W-1:0] irq_enable;
	reg sync_a;
	reg sync_b;
	reg level_q;
	reg ack;
	reg [31:0] next_readdata;
	wire enable = cs_reg[`CS_ENABLE];
	wire [1:0] mode = cs_reg[`CS_MODE_HI:`CS_MODE_LO];
	wire acc = (AVS_READ_I | AVS_WRITE_I) & ~ack;
	// a write lands only at the edge where waitrequest is seen low
	wire wr = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
	wire [7:0] wb = AVS_WRITEDATA_I[7:0];
	wire rise;
	wire fall;
	wire edge_hit;
	wire flag_clr;
	// one wait state per access; readdata stands by the taking edge
	assign AVS_WAITREQUEST_O = acc;
	// no clock gating in wait, stop3 or debug: logic simply runs on
	assign COMPARATOR_ENABLE_O = enable;
	assign DAC_ENABLE_O = enable;
	assign HYSTERESIS_SEL_O = cs_reg[`CS_HYST];
	assign POSITIVE_INPUT_SELECT_O = in_sel[`C0_POS_HI:`C0_POS_LO];
	assign NEGATIVE_INPUT_SELECT_O = in_sel[`C0_NEG_HI:`C0_NEG_LO];
	assign DAC_CODE_O = ctrl_one[DAC_BITS-1:0];
	assign DAC_REF_SEL_O = ctrl_one[`C1_REF_SEL];
	assign CONTROL_TWO_O = ctrl_two;
	// first stage feeds only the second; inversion applied after sync
	always @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			level_q <= 1'b0;
		end else begin
			sync_a <= COMPARATOR_RAW_I;
			sync_b <= sync_a;
			level_q <= enable & (sync_b ^ ctrl_one[`C1_INVERT]);
		end
	end
	// edge appears at level_q three clocks after the raw edge
	assign rise = ~level_q & enable & (sync_b ^ ctrl_one[`C1_INVERT]);
	assign fall = level_q & ~(enable & (sync_b ^ ctrl_one[`C1_INVERT]));
	assign edge_hit = (mode == `MODE_RISE) ? rise :
		(mode == `MODE_BOTH) ? (rise | fall) : fall;
	assign flag_clr = wr & (AVS_ADDRESS_I == `CMP_ADDR_CS) &
		~wb[`CS_FLAG];
	always @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cs_reg <= `CMP_RESET_BYTE;
			in_sel <= `CMP_RESET_BYTE;
			ctrl_one <= `CMP_RESET_BYTE;
			ctrl_two <= `CMP_RESET_BYTE;
			irq_status <= {`STAT_W{1'b0}};
			irq_enable <= {`STAT_W{1'b0}};
			ack <= 1'b0;
			AVS_READDATA_O <= `CMP_UNMAPPED_READ;
			PIN_OUT_O <= 1'b0;
		end else begin
			ack <= acc;
			PIN_OUT_O <= level_q & cs_reg[`CS_PIN_EN];
			// set wins over a same-cycle clear
			if (edge_hit)
				cs_reg[`CS_FLAG] <= 1'b1;
			else if (flag_clr)
				cs_reg[`CS_FLAG] <= 1'b0;
			if (edge_hit)
				irq_status[`STAT_EDGE] <= 1'b1;
			else if (wr && AVS_ADDRESS_I == `CMP_ADDR_IRQ_CLEAR &&
				wb[`STAT_EDGE])
				irq_status[`STAT_EDGE] <= 1'b0;
			if (wr) begin
				case (AVS_ADDRESS_I)
				`CMP_ADDR_CS: begin
					cs_reg[`CS_ENABLE] <= wb[`CS_ENABLE];
					cs_reg[`CS_HYST] <= wb[`CS_HYST];
					cs_reg[`CS_IRQ_EN] <= wb[`CS_IRQ_EN];
					cs_reg[`CS_PIN_EN] <= wb[`CS_PIN_EN];
					cs_reg[`CS_MODE_HI:`CS_MODE_LO] <=
						wb[`CS_MODE_HI:`CS_MODE_LO];
				end
				`CMP_ADDR_C0: in_sel <= wb & `C0_WRITE_MASK;
				`CMP_ADDR_C1: ctrl_one <= wb;
				`CMP_ADDR_C2: ctrl_two <= wb;
				`CMP_ADDR_IRQ_ENABLE: irq_enable <= wb[`STAT_W-1:0];
				default: ;
				endcase
			end
			if (acc)
				AVS_READDATA_O <= next_readdata;
		end
	end
	always @* begin
		next_readdata = `CMP_UNMAPPED_READ;
		if (AVS_READ_I) begin
			case (AVS_ADDRESS_I)
			`CMP_ADDR_CS: begin
				next_readdata[7:0] = cs_reg;
				next_readdata[`CS_LEVEL] = level_q;
			end
			`CMP_ADDR_C0: next_readdata[7:0] = in_sel;
			`CMP_ADDR_C1: next_readdata[7:0] = ctrl_one;
			`CMP_ADDR_C2: next_readdata[7:0] = ctrl_two;
			`CMP_ADDR_IRQ_STATUS: next_readdata[`STAT_W-1:0] = irq_status;
			`CMP_ADDR_IRQ_ENABLE: next_readdata[`STAT_W-1:0] = irq_enable;
			default: next_readdata = `CMP_UNMAPPED_READ;
			endcase
		end
	end
	// settings persist across stop3 since only reset or a register write changes them
	assign EDGE_IRQ_O = cs_reg[`CS_FLAG] & cs_reg[`CS_IRQ_EN];
	assign IRQ_O = |(irq_status & irq_enable);
	assign PIN_OE_O = cs_reg[`CS_PIN_EN];
endmodule // analog_comparator_ctrl
`default_nettype wire

// ===== include/cmp_defs.vh
// constants for the analog comparator control block
// Operation
// - keeps running in wait, irq wakes
// - comparator and dac keep running in stop3
// - enabled edge irq wakes from stop3
// - stop3 exit by irq keeps settings
// - stop3 exit by reset restores defaults
// - runs normally in background debug
// - pin enable gates output onto pin
// - six-bit dac code, 64 taps
// - dac reference supply or bandgap
// - edge detect rising, falling or both
// - optional output inversion
// - three selectable comparator inputs, code 10 reserved
// - four 8-bit registers reset to zero
// - edge select 00/10 fall,01 rise,11 both
// - flag set three clocks late, write0 clears
// - input select 00 ref0,01 ref1,11 dac
`ifndef CMP_DEFS_VH
`define CMP_DEFS_VH
`define CMP_ADDR_W 6
`define CMP_ADDR_CS 6'h2c
`define CMP_ADDR_C0 6'h2d
`define CMP_ADDR_C1 6'h2e
`define CMP_ADDR_C2 6'h2f
`define CMP_ADDR_IRQ_STATUS 6'h30
`define CMP_ADDR_IRQ_CLEAR 6'h31
`define CMP_ADDR_IRQ_ENABLE 6'h32
`define CMP_RESET_BYTE 8'h00
`define CMP_UNMAPPED_READ 32'h00000000
`define CS_ENABLE 7
`define CS_HYST 6
`define CS_FLAG 5
`define CS_IRQ_EN 4
`define CS_LEVEL 3
`define CS_PIN_EN 2
`define CS_MODE_HI 1
`define CS_MODE_LO 0
`define C0_POS_HI 5
`define C0_POS_LO 4
`define C0_NEG_HI 1
`define C0_NEG_LO 0
`define C0_WRITE_MASK 8'h33
`define C1_DAC_HI 5
`define C1_DAC_LO 0
`define C1_REF_SEL 6
`define C1_INVERT 7
`define MODE_FALL_A 2'h0
`define MODE_RISE 2'h1
`define MODE_FALL_B 2'h2
`define MODE_BOTH 2'h3
`define SEL_EXT0 2'h0
`define SEL_EXT1 2'h1
`define SEL_RSVD 2'h2
`define SEL_DAC 2'h3
`define STAT_EDGE 0
`define STAT_W 1
`endif

// ===== test/analog_comparator_control_assertions.sv
// port checker for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmp_chk #(parameter DAC_BITS = 6) (
	input wire CORE_CLK_I,
	input wire RST_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire AVS_WAITREQUEST_O,
	input wire COMPARATOR_ENABLE_O,
	input wire DAC_ENABLE_O,
	input wire [1:0] POSITIVE_INPUT_SELECT_O,
	input wire [DAC_BITS-1:0] DAC_CODE_O,
	input wire PIN_OUT_O,
	input wire PIN_OE_O,
	input wire IRQ_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	sequence req_begin; $rose(AVS_READ_I || AVS_WRITE_I); endsequence
	sequence one_wait; AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O; endsequence
	access_wait_a: assert property (req_begin |-> one_wait)
		else $error("waitrequest not one cycle");
	idle_ready_a: assert property (!(AVS_READ_I || AVS_WRITE_I)
		|-> !AVS_WAITREQUEST_O) else $error("waitrequest while idle");
	en_pair_a: assert property (COMPARATOR_ENABLE_O == DAC_ENABLE_O)
		else $error("dac enable split");
	pin_gate_a: assert property (!PIN_OE_O && !$past(PIN_OE_O)
		|-> !PIN_OUT_O) else $error("pin driven while gated");
	reset_clear_a: assert property ($fell(RST_I) |-> !IRQ_O &&
		!COMPARATOR_ENABLE_O && !PIN_OE_O && DAC_CODE_O == 0)
		else $error("state not cleared");
	// dac code, positive select, pin enable and comparator enable may only move when a write is taken, also across low power
	dac_hold_a: assert property (!AVS_WRITE_I |=> $stable(DAC_CODE_O))
		else $error("dac code moved");
	sel_hold_a: assert property (!AVS_WRITE_I |=>
		$stable(POSITIVE_INPUT_SELECT_O)) else $error("select moved");
	en_hold_a: assert property (!AVS_WRITE_I |=> $stable(PIN_OE_O) &&
		$stable(COMPARATOR_ENABLE_O)) else $error("enable moved");
endmodule // cmp_chk
bind analog_comparator_ctrl cmp_chk #(.DAC_BITS(DAC_BITS)) u_chk (
	.CORE_CLK_I, .RST_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O,
	.COMPARATOR_ENABLE_O, .DAC_ENABLE_O, .POSITIVE_INPUT_SELECT_O,
	.DAC_CODE_O, .PIN_OUT_O, .PIN_OE_O, .IRQ_O);
`default_nettype wire

// ===== test/analog_comparator_control_bench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defs.vh"
module analog_comparator_control_bench;
	logic clk = 0, rst = 1, rd = 0, wr = 0, raw = 0;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0;
	logic [3:0] be = 4'h1;
	wire [1:0] ns;
	wire [7:0] c2;
	wire ce, hy, de;
	logic [7:0] q, d;
	wire [31:0] rdat;
	wire [5:0] dac;
	wire [1:0] ps;
	wire wq, rs, pin, oe, ei, irq;
	integer failures = 0, samples_checked = 0, seed = 32'hb30e, m, v;
	always #2 clk = ~clk;
	analog_comparator_ctrl DUT (.CORE_CLK_I(clk), .RST_I(rst),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wq), .COMPARATOR_RAW_I(raw),
		.COMPARATOR_ENABLE_O(ce), .HYSTERESIS_SEL_O(hy),
		.POSITIVE_INPUT_SELECT_O(ps), .NEGATIVE_INPUT_SELECT_O(ns),
		.DAC_CODE_O(dac), .DAC_REF_SEL_O(rs), .DAC_ENABLE_O(de),
		.CONTROL_TWO_O(c2), .PIN_OUT_O(pin), .PIN_OE_O(oe),
		.EDGE_IRQ_O(ei), .IRQ_O(irq));
	task end_of_test;
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, got, exp);
		end
	endtask
	// one edge passes first so a request is never raised where it fell
	task acc(input [5:0] a, input w, input [7:0] dat);
		integer n;
		@(posedge clk);
		{adr, wr, rd, wd} <= {a, w, !w, 24'h0, dat};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wq !== 1'b0 && n < 20);
		q = rdat[7:0];
		{wr, rd} <= 2'b00;
		if (n == 20) begin
			failures++;
			end_of_test;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		for (m = 0; m < 5; m++) begin
			acc(m == 4 ? 6'h3f : 6'h2c + m[5:0], 0, 0);
			chk(q, 0);
		end
		repeat (4) begin
			d = $random(seed);
			acc(`CMP_ADDR_C1, 1, d);
			acc(`CMP_ADDR_C1, 0, 0);
			chk(q, d);
			chk({dac, rs}, {d[5:0], d[6]});
			acc(`CMP_ADDR_C0, 1, d);
			acc(`CMP_ADDR_C0, 0, 0);
			chk(q, d & 8'h33);
			chk(ps, d[5:4]);
			chk(ns, d[1:0]);
			acc(`CMP_ADDR_C2, 1, d);
			acc(`CMP_ADDR_C2, 0, 0);
			chk(q, d);
			chk(c2, d);
		end
		$display("register test done");
		for (m = 0; m < 4; m++) begin
			acc(`CMP_ADDR_CS, 1, {6'h24, m[1:0]});
			for (v = 1; v >= 0; v--) begin
				raw <= v[0];
				repeat (6) @(posedge clk);
				acc(`CMP_ADDR_CS, 0, 0);
				chk(q[5], v ? m[0] : m != 1);
				chk(ei, v ? m[0] : m != 1);
				chk(q[3], v[0]);
				acc(`CMP_ADDR_CS, 1, {6'h24, m[1:0]});
			end
		end
		$display("edge test done");
		acc(`CMP_ADDR_CS, 1, 8'h84);
		raw <= 1;
		repeat (5) @(posedge clk);
		chk({oe, pin}, 2'b11);
		chk({ce, de, hy}, 3'b110);
		acc(`CMP_ADDR_CS, 1, 8'h80);
		raw <= 0;
		repeat (6) @(posedge clk);
		chk({oe, pin}, 0);
		acc(`CMP_ADDR_IRQ_ENABLE, 1, 1);
		@(negedge clk);
		chk(irq, 1);
		acc(`CMP_ADDR_IRQ_CLEAR, 1, 1);
		@(negedge clk);
		chk(irq, 0);
		$display("pin and irq test done");
		acc(`CMP_ADDR_C1, 1, 8'h3f);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		acc(`CMP_ADDR_C1, 0, 0);
		chk(q, 0);
		be <= 4'h0;
		acc(`CMP_ADDR_C1, 1, 8'h3f);
		be <= 4'h1;
		acc(`CMP_ADDR_C1, 0, 0);
		chk(q, 0);
		$display("reset test done");
		end_of_test;
	end
endmodule // analog_comparator_control_bench
`default_nettype wire
